// >>> hw/lmpcd_pkg.sv
// constants and types shared by the command decoder files
package lmpcd_pkg;
    localparam logic [7:0] FRAME_ID_CMD = 8'h3c;
    localparam logic [7:0] APP_TAG = 8'h80;
    localparam logic [6:0] OP_DUAL = 7'h08;
    localparam logic [6:0] OP_MOTOR = 7'h09;
    localparam logic [6:0] OP_FUSE = 7'h10;
    localparam logic [6:0] OP_STALL = 7'h16;
    localparam logic [3:0] DATA_BYTES = 4'h8;
    localparam logic [3:0] COUNT_OVER = 4'h9;
    localparam logic [3:0] FUSE_MARK = 4'hf;
    // data byte numbers within the frame, counted from one
    localparam int B_TAG = 1;
    localparam int B_OPC = 2;
    localparam int B_ADDR = 3;
    localparam int B_D4 = 4;
    localparam int B_D5 = 5;
    localparam int B_D6 = 6;
    localparam int B_D7 = 7;
    localparam int B_D8 = 8;
    // bit positions
    localparam int TOP_BIT = 7;
    localparam int HI_NIB = 4;
    localparam int LO_NIB = 0;
    localparam int SAMPLES_LSB = 5;
    localparam int DIR_BIT = 4;
    localparam int RATE_LSB = 0;
    localparam int UV_LSB = 0;
    localparam int FSTALL_LSB = 5;
    localparam int PROFILE_BIT = 4;
    localparam int STEP_LSB = 2;
    localparam int DUTY_BIT = 1;
    localparam int JITTER_BIT = 0;
    localparam int SETTLE1_BIT = 7;
    localparam int CHOP_BIT = 6;
    localparam int SETTLE0_BIT = 5;
    localparam int BOOST_BIT = 1;
    localparam int FALLBACK_LSB = 5;
    localparam int FUSE_INV_BIT = 3;
    localparam int FUSE_IDX_LSB = 0;
    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b000,
        SEQ_REQ1 = 3'b001,
        SEQ_RUN1 = 3'b010,
        SEQ_REQ2 = 3'b011,
        SEQ_RUN2 = 3'b100
    } lmpcd_seq_t;
endpackage : lmpcd_pkg

// >>> hw/lmpcd_capture.sv
// collects the data bytes of one frame and flags a complete frame
`timescale 1ns/1ps
module lmpcd_capture (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] frame_id,
    input wire logic frame_start,
    input wire logic byte_valid,
    input wire logic [7:0] byte_data,
    input wire logic frame_end,
    output logic ready,
    output logic [7:0] id,
    output logic [63:0] data
);
    typedef struct packed {
        logic [7:0] id;
        logic [3:0] cnt;
        logic [63:0] data;
        logic ready;
    } lmpcd_cap_t;

    lmpcd_cap_t st;
    lmpcd_cap_t next_st;

    always_comb begin
        next_st = st;
        next_st.ready = 1'b0;
        if (frame_start) begin
            next_st.id = frame_id;
            next_st.cnt = 4'h0;
        end else if (byte_valid) begin
            if (st.cnt < lmpcd_pkg::DATA_BYTES) begin
                next_st.data[st.cnt[2:0]*8 +: 8] = byte_data;
                next_st.cnt = st.cnt + 4'h1;
            end else begin
                // an overlong frame is marked so that it is never decoded
                next_st.cnt = lmpcd_pkg::COUNT_OVER;
            end
        end else if (frame_end) begin
            next_st.ready = (st.cnt == lmpcd_pkg::DATA_BYTES);
            // a repeated end marker without a new start must not decode again
            next_st.cnt = lmpcd_pkg::COUNT_OVER;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign ready = st.ready;
    assign id = st.id;
    assign data = st.data;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    short_frame_a: assert property (
        frame_end && !frame_start && !byte_valid &&
        st.cnt != lmpcd_pkg::DATA_BYTES |=> !ready)
        else $error("frame without eight data bytes was flagged");
endmodule : lmpcd_capture

// >>> hw/lmpcd_dual_seq.sv
// runs the two motions of the dual speed reference move
`timescale 1ns/1ps
module lmpcd_dual_seq (
    input wire logic clk,
    input wire logic rst,
    input wire logic go,
    input wire logic [15:0] first_target,
    input wire logic [15:0] second_move_offset,
    input wire logic [3:0] top_speed,
    input wire logic [3:0] floor_speed,
    input wire logic move_done,
    output logic move_start,
    output logic move_relative,
    output logic [15:0] move_position,
    output logic [3:0] move_top_speed,
    output logic [3:0] move_floor_speed,
    output logic busy,
    output logic reference_done
);
    typedef struct packed {
        lmpcd_pkg::lmpcd_seq_t state;
        logic [15:0] first;
        logic [15:0] offset;
        logic [3:0] top;
        logic [3:0] floor;
        logic start;
        logic relative;
        logic [15:0] pos;
        logic [3:0] top_o;
        logic [3:0] floor_o;
        logic busy;
        logic ref_done;
    } lmpcd_dseq_t;

    lmpcd_dseq_t st;
    lmpcd_dseq_t next_st;

    always_comb begin
        next_st = st;
        next_st.start = 1'b0;
        case (st.state)
            lmpcd_pkg::SEQ_IDLE: begin
                // a go while busy cannot reach here, so it is dropped
                if (go) begin
                    next_st.first = first_target;
                    next_st.offset = second_move_offset;
                    next_st.top = top_speed;
                    next_st.floor = floor_speed;
                    next_st.busy = 1'b1;
                    next_st.state = lmpcd_pkg::SEQ_REQ1;
                end
            end
            lmpcd_pkg::SEQ_REQ1: begin
                next_st.start = 1'b1;
                next_st.relative = 1'b0;
                next_st.pos = st.first;
                next_st.top_o = st.top;
                next_st.floor_o = st.floor;
                next_st.state = lmpcd_pkg::SEQ_RUN1;
            end
            lmpcd_pkg::SEQ_RUN1: begin
                if (move_done) begin
                    next_st.state = lmpcd_pkg::SEQ_REQ2;
                end
            end
            lmpcd_pkg::SEQ_REQ2: begin
                // second motion runs at the floor speed only
                next_st.start = 1'b1;
                next_st.relative = 1'b1;
                next_st.pos = st.offset;
                next_st.top_o = st.floor;
                next_st.floor_o = st.floor;
                next_st.state = lmpcd_pkg::SEQ_RUN2;
            end
            lmpcd_pkg::SEQ_RUN2: begin
                if (move_done) begin
                    next_st.ref_done = 1'b1;
                    next_st.busy = 1'b0;
                    next_st.state = lmpcd_pkg::SEQ_IDLE;
                end
            end
            default: begin
                next_st.busy = 1'b0;
                next_st.state = lmpcd_pkg::SEQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign move_start = st.start;
    assign move_relative = st.relative;
    assign move_position = st.pos;
    assign move_top_speed = st.top_o;
    assign move_floor_speed = st.floor_o;
    assign busy = st.busy;
    assign reference_done = st.ref_done;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence first_finished;
        st.state == lmpcd_pkg::SEQ_RUN1 && move_done;
    endsequence

    second_move_a: assert property (
        first_finished |=> ##1 move_start && move_relative &&
        move_position == $past(st.offset, 2) &&
        move_top_speed == move_floor_speed)
        else $error("second motion not started as expected");

    ref_done_a: assert property (
        st.state == lmpcd_pkg::SEQ_RUN2 && move_done
        |=> reference_done && !busy)
        else $error("reference done not set at sequence end");

    busy_ignore_a: assert property (
        busy |=> $stable(st.first) && $stable(st.offset))
        else $error("positioning accepted while sequence runs");
endmodule : lmpcd_dual_seq

// >>> hw/lmpcd_top.sv
// command decoder for the 0x3c application frames of a motor node
`timescale 1ns/1ps
module lmpcd_top (
    input wire logic MCLK,
    input wire logic RESET,
    input wire logic [7:0] FRAME_ID,
    input wire logic FRAME_START,
    input wire logic BYTE_VALID,
    input wire logic [7:0] BYTE_DATA,
    input wire logic FRAME_END,
    input wire logic [6:0] NODE_ADDR,
    input wire logic MOVE_DONE,
    output logic [3:0] RUN_CURRENT_INDEX,
    output logic [3:0] STANDSTILL_CURRENT_INDEX,
    output logic [3:0] TOP_SPEED_INDEX,
    output logic [3:0] FLOOR_SPEED_INDEX,
    output logic ROTATION_DIR,
    output logic [3:0] RAMP_RATE,
    output logic [2:0] DETECT_SAMPLE_COUNT,
    output logic [3:0] BACKEMF_THRESHOLD,
    output logic [2:0] UNDERVOLT_STALL_THRESHOLD,
    output logic [2:0] FULLSTEP_STALL_DETECT_ON,
    output logic RAMP_PROFILE_SELECT,
    output logic [1:0] STEP_RESOLUTION,
    output logic FULL_DUTY_STALL_ON,
    output logic CHOPPER_JITTER_ON,
    output logic [10:0] FALLBACK_TARGET,
    output logic [1:0] SETTLE_TIME_FIELD,
    output logic CHOPPER_RATE_SELECT,
    output logic COLD_CURRENT_RAISE_OFF,
    output logic STALL_UPDATE,
    output logic PARAM_UPDATE,
    output logic FUSE_PROGRAM,
    output logic [3:0] FUSE_BYTE_INDEX,
    output logic [7:0] FUSE_DATA,
    output logic FRAME_DISCARD,
    output logic MOVE_START,
    output logic MOVE_RELATIVE,
    output logic [15:0] MOVE_POSITION,
    output logic [3:0] MOVE_TOP_SPEED,
    output logic [3:0] MOVE_FLOOR_SPEED,
    output logic DUAL_BUSY,
    output logic REFERENCE_DONE
);
    typedef struct packed {
        logic [3:0] run_cur;
        logic [3:0] hold_cur;
        logic [3:0] top;
        logic [3:0] floor;
        logic dir;
        logic [3:0] rate;
        logic [2:0] samples;
        logic [3:0] bemf;
        logic [2:0] uv;
        logic [2:0] fstall;
        logic profile;
        logic [1:0] step;
        logic duty;
        logic jitter;
        logic [10:0] fallback;
        logic [1:0] settle;
        logic chop;
        logic boost_off;
        logic stall_upd;
        logic param_upd;
        logic fuse_go;
        logic [3:0] fuse_idx;
        logic [7:0] fuse_data;
        logic discard;
    } lmpcd_main_t;

    lmpcd_main_t st;
    lmpcd_main_t next_st;

    logic cap_ready;
    logic [7:0] cap_id;
    logic [63:0] cap_data;
    logic seq_busy;
    logic dual_go;
    logic [7:0] d_tag;
    logic [7:0] d_opc;
    logic [7:0] d_adr;
    logic [7:0] d4;
    logic [7:0] d5;
    logic [7:0] d6;
    logic [7:0] d7;
    logic [7:0] d8;
    logic frame_ok;
    logic addressed;
    logic [6:0] opcode;

    function automatic logic [7:0] data_byte(input logic [63:0] d,
                                             input int n);
        return d[8*(n-1) +: 8];
    endfunction : data_byte

    lmpcd_capture u_capture (
        .clk(MCLK),
        .rst(RESET),
        .frame_id(FRAME_ID),
        .frame_start(FRAME_START),
        .byte_valid(BYTE_VALID),
        .byte_data(BYTE_DATA),
        .frame_end(FRAME_END),
        .ready(cap_ready),
        .id(cap_id),
        .data(cap_data)
    );

    assign d_tag = data_byte(cap_data, lmpcd_pkg::B_TAG);
    assign d_opc = data_byte(cap_data, lmpcd_pkg::B_OPC);
    assign d_adr = data_byte(cap_data, lmpcd_pkg::B_ADDR);
    assign d4 = data_byte(cap_data, lmpcd_pkg::B_D4);
    assign d5 = data_byte(cap_data, lmpcd_pkg::B_D5);
    assign d6 = data_byte(cap_data, lmpcd_pkg::B_D6);
    assign d7 = data_byte(cap_data, lmpcd_pkg::B_D7);
    assign d8 = data_byte(cap_data, lmpcd_pkg::B_D8);
    assign opcode = d_opc[6:0];

    assign frame_ok = cap_id == lmpcd_pkg::FRAME_ID_CMD &&
        d_tag == lmpcd_pkg::APP_TAG && d_opc[lmpcd_pkg::TOP_BIT];
    assign addressed = !d_adr[lmpcd_pkg::TOP_BIT] ||
        d_adr[6:0] == NODE_ADDR;

    // busy check here means a refused move never reaches the sequencer
    assign dual_go = cap_ready && frame_ok && addressed &&
        opcode == lmpcd_pkg::OP_DUAL && !seq_busy;

    always_comb begin
        next_st = st;
        next_st.stall_upd = 1'b0;
        next_st.param_upd = 1'b0;
        next_st.fuse_go = 1'b0;
        next_st.discard = 1'b0;
        if (cap_ready) begin
            if (!frame_ok || !addressed) begin
                next_st.discard = 1'b1;
            end else begin
                case (opcode)
                    lmpcd_pkg::OP_DUAL: begin
                        next_st.discard = seq_busy;
                    end
                    lmpcd_pkg::OP_STALL: begin
                        next_st.run_cur = d4[lmpcd_pkg::HI_NIB +: 4];
                        next_st.hold_cur = d4[lmpcd_pkg::LO_NIB +: 4];
                        next_st.top = d5[lmpcd_pkg::HI_NIB +: 4];
                        next_st.floor = d5[lmpcd_pkg::LO_NIB +: 4];
                        next_st.samples = d6[lmpcd_pkg::SAMPLES_LSB +: 3];
                        next_st.dir = d6[lmpcd_pkg::DIR_BIT];
                        next_st.rate = d6[lmpcd_pkg::RATE_LSB +: 4];
                        next_st.bemf = d7[lmpcd_pkg::HI_NIB +: 4];
                        next_st.uv = d7[lmpcd_pkg::UV_LSB +: 3];
                        next_st.fstall = d8[lmpcd_pkg::FSTALL_LSB +: 3];
                        next_st.profile = d8[lmpcd_pkg::PROFILE_BIT];
                        next_st.step = d8[lmpcd_pkg::STEP_LSB +: 2];
                        next_st.duty = d8[lmpcd_pkg::DUTY_BIT];
                        next_st.jitter = d8[lmpcd_pkg::JITTER_BIT];
                        next_st.stall_upd = 1'b1;
                    end
                    lmpcd_pkg::OP_MOTOR: begin
                        next_st.run_cur = d4[lmpcd_pkg::HI_NIB +: 4];
                        next_st.hold_cur = d4[lmpcd_pkg::LO_NIB +: 4];
                        next_st.top = d5[lmpcd_pkg::HI_NIB +: 4];
                        next_st.floor = d5[lmpcd_pkg::LO_NIB +: 4];
                        next_st.dir = d6[lmpcd_pkg::DIR_BIT];
                        next_st.rate = d6[lmpcd_pkg::RATE_LSB +: 4];
                        next_st.fallback =
                            {d6[lmpcd_pkg::FALLBACK_LSB +: 3], d7};
                        next_st.settle =
                            {d8[lmpcd_pkg::SETTLE1_BIT],
                             d8[lmpcd_pkg::SETTLE0_BIT]};
                        next_st.chop = d8[lmpcd_pkg::CHOP_BIT];
                        next_st.profile = d8[lmpcd_pkg::PROFILE_BIT];
                        next_st.step = d8[lmpcd_pkg::STEP_LSB +: 2];
                        next_st.boost_off = d8[lmpcd_pkg::BOOST_BIT];
                        next_st.jitter = d8[lmpcd_pkg::JITTER_BIT];
                        // applied whether a motion runs or not
                        next_st.param_upd = 1'b1;
                    end
                    lmpcd_pkg::OP_FUSE: begin
                        // padding bytes 6 to 8 are not looked at
                        if (d4[lmpcd_pkg::HI_NIB +: 4] ==
                            lmpcd_pkg::FUSE_MARK) begin
                            next_st.fuse_idx =
                                {~d4[lmpcd_pkg::FUSE_INV_BIT],
                                 d4[lmpcd_pkg::FUSE_IDX_LSB +: 3]};
                            next_st.fuse_data = d5;
                            next_st.fuse_go = 1'b1;
                        end else begin
                            next_st.discard = 1'b1;
                        end
                    end
                    default: begin
                        next_st.discard = 1'b1;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    lmpcd_dual_seq u_dual_seq (
        .clk(MCLK),
        .rst(RESET),
        .go(dual_go),
        .first_target({d5, d6}),
        .second_move_offset({d7, d8}),
        .top_speed(d4[lmpcd_pkg::HI_NIB +: 4]),
        .floor_speed(d4[lmpcd_pkg::LO_NIB +: 4]),
        .move_done(MOVE_DONE),
        .move_start(MOVE_START),
        .move_relative(MOVE_RELATIVE),
        .move_position(MOVE_POSITION),
        .move_top_speed(MOVE_TOP_SPEED),
        .move_floor_speed(MOVE_FLOOR_SPEED),
        .busy(seq_busy),
        .reference_done(REFERENCE_DONE)
    );

    assign DUAL_BUSY = seq_busy;
    assign RUN_CURRENT_INDEX = st.run_cur;
    assign STANDSTILL_CURRENT_INDEX = st.hold_cur;
    assign TOP_SPEED_INDEX = st.top;
    assign FLOOR_SPEED_INDEX = st.floor;
    assign ROTATION_DIR = st.dir;
    assign RAMP_RATE = st.rate;
    assign DETECT_SAMPLE_COUNT = st.samples;
    assign BACKEMF_THRESHOLD = st.bemf;
    assign UNDERVOLT_STALL_THRESHOLD = st.uv;
    assign FULLSTEP_STALL_DETECT_ON = st.fstall;
    assign RAMP_PROFILE_SELECT = st.profile;
    assign STEP_RESOLUTION = st.step;
    assign FULL_DUTY_STALL_ON = st.duty;
    assign CHOPPER_JITTER_ON = st.jitter;
    assign FALLBACK_TARGET = st.fallback;
    assign SETTLE_TIME_FIELD = st.settle;
    assign CHOPPER_RATE_SELECT = st.chop;
    assign COLD_CURRENT_RAISE_OFF = st.boost_off;
    assign STALL_UPDATE = st.stall_upd;
    assign PARAM_UPDATE = st.param_upd;
    assign FUSE_PROGRAM = st.fuse_go;
    assign FUSE_BYTE_INDEX = st.fuse_idx;
    assign FUSE_DATA = st.fuse_data;
    assign FRAME_DISCARD = st.discard;

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RESET);

    tag_check_a: assert property (
        STALL_UPDATE || PARAM_UPDATE || FUSE_PROGRAM |->
        $past(cap_ready && cap_id == lmpcd_pkg::FRAME_ID_CMD &&
              d_tag == lmpcd_pkg::APP_TAG))
        else $error("settings applied from a foreign frame");

    stall_opcode_a: assert property (
        STALL_UPDATE |-> $past(opcode) == lmpcd_pkg::OP_STALL &&
        BACKEMF_THRESHOLD == $past(d7[lmpcd_pkg::HI_NIB +: 4]))
        else $error("stall settings written by wrong opcode");

    fuse_index_a: assert property (
        FUSE_PROGRAM |-> FUSE_BYTE_INDEX ==
        {~$past(d4[3]), $past(d4[2:0])} && FUSE_DATA == $past(d5))
        else $error("fuse index or data wrong");

    station_match_a: assert property (
        STALL_UPDATE || PARAM_UPDATE || FUSE_PROGRAM |->
        $past(!d_adr[7] || d_adr[6:0] == NODE_ADDR))
        else $error("settings applied for another station");

    discard_a: assert property (
        cap_ready && !frame_ok |=> FRAME_DISCARD && !PARAM_UPDATE &&
        !STALL_UPDATE && $stable(FALLBACK_TARGET) && $stable(RAMP_RATE))
        else $error("bad frame changed state");

    fallback_a: assert property (
        PARAM_UPDATE |-> FALLBACK_TARGET == {$past(d6[7:5]), $past(d7)})
        else $error("fallback target assembled wrong");
endmodule : lmpcd_top

// >>> tb/lmpcd_master_model.sv
// frame source standing in for the bus master of the command decoder
`timescale 1ns/1ps
module lmpcd_master_model (
    input wire logic clk,
    input wire logic send,
    input wire logic [63:0] frame,
    input wire logic [3:0] byte_total,
    output logic frame_start = 1'b0,
    output logic byte_valid = 1'b0,
    output logic [7:0] byte_data = 8'h00,
    output logic frame_end = 1'b0
);
    logic [3:0] cnt = 4'h0;
    logic [63:0] sh = 64'h0;
    // byte_total data bytes, tag byte first, then the good-checksum marker
    always @(posedge clk) begin
        frame_start <= 1'b0;
        byte_valid <= 1'b0;
        frame_end <= 1'b0;
        // outside the byte cycles the data lines invert every cycle, so they hold the last byte every second cycle
        byte_data <= ~byte_data;
        if (cnt == 4'h0) begin
            if (send) begin
                frame_start <= 1'b1;
                sh <= frame;
                cnt <= 4'h1;
            end
        end else if (cnt == byte_total + 4'h1) begin
            frame_end <= 1'b1;
            cnt <= 4'h0;
        end else begin
            byte_valid <= 1'b1;
            byte_data <= sh[63:56];
            sh <= sh << 8;
            cnt <= cnt + 4'h1;
        end
    end
endmodule : lmpcd_master_model

// >>> tb/tb.sv
// self-checking bench for the command decoder
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; \
 $display("wrong value at %0t: got %h want %h", $time, g, e); end end
module tb;
    logic MCLK = 1'b0;
    logic RESET = 1'b1;
    logic [7:0] fid = 8'h3c;
    logic mdone = 1'b0;
    logic send = 1'b0;
    logic [63:0] frame = 64'h0;
    logic [3:0] nbytes = 4'h8;
    logic fs, bv, fe, dir, prof, duty, jit, chop, boost, su, pu, fp, fd;
    logic ms, mrel, busy, rdone;
    logic [7:0] bd, fdat;
    logic [3:0] run, hold, top, flr, rate, emf, fidx, mtop, mflr;
    logic [2:0] smp, uv, fst;
    logic [1:0] stp, stl;
    logic [10:0] fb;
    logic [15:0] mpos;
    int mismatches = 0;
    int checked = 0;
    int cycles = 0;
    lmpcd_master_model lm (.clk(MCLK), .send(send), .frame(frame),
        .byte_total(nbytes), .frame_start(fs), .byte_valid(bv),
        .byte_data(bd), .frame_end(fe));
    lmpcd_top dut (.MCLK(MCLK), .RESET(RESET), .FRAME_ID(fid),
        .FRAME_START(fs), .BYTE_VALID(bv), .BYTE_DATA(bd), .FRAME_END(fe),
        .NODE_ADDR(7'h2a), .MOVE_DONE(mdone), .RUN_CURRENT_INDEX(run),
        .STANDSTILL_CURRENT_INDEX(hold), .TOP_SPEED_INDEX(top),
        .FLOOR_SPEED_INDEX(flr), .ROTATION_DIR(dir), .RAMP_RATE(rate),
        .DETECT_SAMPLE_COUNT(smp), .BACKEMF_THRESHOLD(emf),
        .UNDERVOLT_STALL_THRESHOLD(uv), .FULLSTEP_STALL_DETECT_ON(fst),
        .RAMP_PROFILE_SELECT(prof), .STEP_RESOLUTION(stp),
        .FULL_DUTY_STALL_ON(duty), .CHOPPER_JITTER_ON(jit),
        .FALLBACK_TARGET(fb), .SETTLE_TIME_FIELD(stl),
        .CHOPPER_RATE_SELECT(chop), .COLD_CURRENT_RAISE_OFF(boost),
        .STALL_UPDATE(su), .PARAM_UPDATE(pu), .FUSE_PROGRAM(fp),
        .FUSE_BYTE_INDEX(fidx), .FUSE_DATA(fdat), .FRAME_DISCARD(fd),
        .MOVE_START(ms), .MOVE_RELATIVE(mrel), .MOVE_POSITION(mpos),
        .MOVE_TOP_SPEED(mtop), .MOVE_FLOOR_SPEED(mflr), .DUAL_BUSY(busy),
        .REFERENCE_DONE(rdone));
    initial begin
        forever #25 MCLK = ~MCLK;
    end
    task automatic tally_and_finish();
        if (mismatches == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish
    // f is {identifier, data bytes 1..8}; p is {stall, motor, fuse, discard}
    task automatic xfer(input logic [71:0] f, input logic [3:0] p);
        @(posedge MCLK);
        fid <= f[71:64];
        frame <= f[63:0];
        send <= 1'b1;
        @(posedge MCLK);
        send <= 1'b0;
        repeat (11) @(posedge MCLK);
        #1;
        `CHK({su, pu, fp, fd}, p)
        @(posedge MCLK);
        #1;
        `CHK({su, pu, fp, fd}, 4'h0)
    endtask : xfer
    task automatic t_motor();
        xfer(72'h3c_80_89_05_a5_3c_d7_5e_a9, 4'h4);
        `CHK({run, hold, top, flr}, 16'ha53c)
        `CHK({dir, rate, fb}, 16'hbe5e)
        `CHK({stl, chop, prof, stp, boost, jit}, 8'hc9)
    endtask : t_motor
    task automatic t_stall();
        xfer(72'h3c_80_96_aa_4b_12_6e_b5_f6, 4'h8);
        `CHK({run, hold, top, flr}, 16'h4b12)
        `CHK({smp, dir, rate, emf, uv}, 15'h375d)
        `CHK({fst, prof, stp, duty, jit}, 8'hf6)
        `CHK(fb, 11'h65e)
    endtask : t_stall
    task automatic t_reject();
        logic [71:0] bad [6];
        bad = '{72'h3d_80_96_aa_99_99_00_00_00, 72'h3c_81_96_aa_99_99_00_00_00,
            72'h3c_80_16_aa_99_99_00_00_00, 72'h3c_80_8a_aa_99_99_00_00_00,
            72'h3c_80_96_ab_99_99_00_00_00, 72'h3c_80_90_00_e5_c3_ff_ff_ff};
        foreach (bad[i]) begin
            xfer(bad[i], 4'h1);
            `CHK({run, hold, smp, fidx}, 15'h25b0)
        end
        // cut and overlong frames must give no answer at all
        @(posedge MCLK);
        nbytes <= 4'h7;
        xfer(72'h3c_80_96_aa_99_99_00_00_00, 4'h0);
        @(posedge MCLK);
        nbytes <= 4'h9;
        xfer(72'h3c_80_96_aa_99_99_00_00_00, 4'h0);
        @(posedge MCLK);
        nbytes <= 4'h8;
        `CHK({run, hold, smp, fidx}, 15'h25b0)
    endtask : t_reject
    task automatic t_fuse();
        // unused tail bytes padded with ones
        xfer(72'h3c_80_90_05_f5_c3_ff_ff_ff, 4'h2);
        `CHK({fidx, fdat}, 12'hdc3)
        xfer(72'h3c_80_90_05_fa_3c_ff_ff_ff, 4'h2);
        `CHK({fidx, fdat}, 12'h23c)
    endtask : t_fuse
    task automatic t_dual();
        xfer(72'h3c_80_88_05_7a_12_34_00_56, 4'h0);
        `CHK({ms, mrel, mpos, mtop, mflr, busy}, 27'h42468f5)
        xfer(72'h3c_80_88_05_31_ff_ff_ff_ff, 4'h1);
        // motor settings still apply while the motion runs; the move outputs stay put
        xfer(72'h3c_80_89_05_a5_61_d7_5e_a9, 4'h4);
        `CHK({top, flr, ms, mpos}, 25'hc21234)
        @(posedge MCLK);
        mdone <= 1'b1;
        @(posedge MCLK);
        mdone <= 1'b0;
        @(posedge MCLK);
        #1;
        `CHK({ms, mrel, mpos, mtop, mflr, rdone}, 27'h600ad54)
        @(posedge MCLK);
        mdone <= 1'b1;
        #1;
        `CHK({busy, rdone}, 2'b10)
        @(posedge MCLK);
        mdone <= 1'b0;
        #1;
        `CHK({busy, rdone}, 2'b01)
    endtask : t_dual
    always @(posedge MCLK) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (4) @(posedge MCLK);
        RESET <= 1'b0;
        #1;
        `CHK({busy, rdone, fb, run, su, fd, ms}, 20'h0)
        t_motor();
        t_stall();
        t_reject();
        t_fuse();
        t_dual();
        tally_and_finish();
    end
endmodule : tb
